// >>> sact_defines.svh
// Purpose: Offsets, field positions, reset values and bus response codes of the slope capture timer
// Assumes: Register byte address is four times the register index
// Notes:   Included by bare name; definitions only
`ifndef SACT_DEFINES_SVH
`define SACT_DEFINES_SVH

// Register indices, compared against address bits 11:2
`define SACT_IDX_FLAGS      10'h00c
`define SACT_IDX_IRQ_EN     10'h00d
`define SACT_IDX_CNT_LO     10'h00e
`define SACT_IDX_CNT_HI     10'h00f
`define SACT_IDX_CAP_LO     10'h015
`define SACT_IDX_CAP_HI     10'h016
`define SACT_IDX_CTRL       10'h01f

// Control register fields
`define SACT_CTRL_CHAN_MSB  7
`define SACT_CTRL_CHAN_LSB  4
`define SACT_CTRL_AMUX_BIT  2
`define SACT_CTRL_HOLD_BIT  1
`define SACT_CTRL_ZERO_BIT  0
`define SACT_CTRL_RESET     8'h02

// Flag and enable register fields
`define SACT_FLAG_CAP_BIT   1
`define SACT_FLAG_WRAP_BIT  0

// Reset values and the last count before the counter wraps
`define SACT_CNT_RESET      16'h0000
`define SACT_CAP_RESET      16'h0000
`define SACT_CNT_LAST       16'hffff

// Bus responses
`define SACT_RESP_OKAY      2'h0
`define SACT_RESP_SLVERR    2'h2

`endif

// >>> sact_pkg.sv
// Purpose: Types shared by the slope capture timer files
// Assumes: Nothing
// Notes:   Never imported; always referenced with the package scope
package sact_pkg;

    typedef enum logic [1:0] {
        SACT_IDLE   = 2'b00,
        SACT_RUN    = 2'b01,
        SACT_PAUSED = 2'b10
    } sact_state_t;

endpackage

// >>> sact_flag.sv
// Purpose: One sticky event flag
// Assumes: Clear request is a one-cycle software pulse
// Notes:   A set in the same cycle as a clear wins
`timescale 1ns/1ps
module sact_flag (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // Event and clear
    input  wire logic setEvent,
    input  wire logic clearReq,
    // State
    output logic      flag
);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            flag <= 1'b0;
        end else if (ce) begin
            if (setEvent) begin
                flag <= 1'b1;
            end else if (clearReq) begin
                flag <= 1'b0;
            end
        end
    end

endmodule

// >>> sact_axil_slave.sv
// Purpose: AXI4-Lite slave front end for the slope capture timer registers
// Assumes: Register file decodes the address and answers combinationally
// Notes:   One write and one read in flight; a write answers one cycle after its last item is taken, a read at the edge that takes the address
`timescale 1ns/1ps
`include "sact_defines.svh"
module sact_axil_slave (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // Write address and data
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // Write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // Read address and data
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Register file side
    output logic             regWrite,
    output logic [11:0]      regWrAddr,
    output logic [7:0]       regWrData,
    input  wire logic        regWrHit,
    output logic [11:0]      regRdAddr,
    input  wire logic [7:0]  regRdData,
    input  wire logic        regRdHit
);

    logic        awHeld;
    logic        wHeld;
    logic        strbLow;
    logic [7:0]  wDataQ;
    wire         awTake = s_axi_awvalid & s_axi_awready & ce;
    wire         wTake  = s_axi_wvalid & s_axi_wready & ce;
    wire         arTake = s_axi_arvalid & s_axi_arready & ce;
    wire         doWrite = awHeld & wHeld & ~s_axi_bvalid & ce;

    assign s_axi_awready = ~awHeld;
    assign s_axi_wready  = ~wHeld;
    assign s_axi_arready = ~s_axi_rvalid;
    // Only byte lane 0 carries register data; other lanes are dropped
    assign regWrite      = doWrite & strbLow;
    assign regWrData     = wDataQ;
    assign regRdAddr     = s_axi_araddr;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            strbLow      <= 1'b0;
            wDataQ       <= 8'h00;
            regWrAddr    <= 12'h000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SACT_RESP_OKAY;
        end else if (ce) begin
            if (awTake) begin
                awHeld    <= 1'b1;
                regWrAddr <= s_axi_awaddr;
            end
            if (wTake) begin
                wHeld   <= 1'b1;
                wDataQ  <= s_axi_wdata[7:0];
                strbLow <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= regWrHit ? `SACT_RESP_OKAY : `SACT_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `SACT_RESP_OKAY;
        end else if (ce) begin
            if (arTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, regRdData};
                s_axi_rresp  <= regRdHit ? `SACT_RESP_OKAY : `SACT_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// >>> sact_top.sv
// Purpose: Capture timer and conversion control of a slope analog-to-digital converter
// Assumes: Comparator output is synchronous to clk; clk is the device oscillator
// Notes:   Registers are byte wide in the low lane of an AXI4-Lite word
`timescale 1ns/1ps
`include "sact_defines.svh"
module sact_top (
    // Clock, enable and reset
    input  wire logic        clk,
    input  wire logic        ce,
    input  wire logic        resetn,
    // AXI4-Lite write channels
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog side
    input  wire logic        comparatorOut,
    output logic             rampDischarge,
    output logic             rampCurrentOn,
    output logic             analogPowerOn,
    output logic             counterClockOn,
    output logic [3:0]       inputChannelSelect,
    output logic             amuxOutEnable,
    output logic             zeroEnable,
    // Interrupt requests
    output logic             captureIrq,
    output logic             wrapIrq
);

    // Register bus front end
    logic        regWrite;
    logic [11:0] regWrAddr;
    logic [7:0]  regWrData;
    logic [11:0] regRdAddr;
    wire  [7:0]  regRdData;
    wire         regWrHit;
    wire         regRdHit;

    sact_axil_slave u_bus (
        .clk           (clk),
        .resetn        (resetn),
        .ce            (ce),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .regWrite      (regWrite),
        .regWrAddr     (regWrAddr),
        .regWrData     (regWrData),
        .regWrHit      (regWrHit),
        .regRdAddr     (regRdAddr),
        .regRdData     (regRdData),
        .regRdHit      (regRdHit)
    );

    // Register state
    logic [15:0]          rampCountTimer;
    logic [15:0]          rampCaptureReg;
    logic [7:0]           convControlReg;
    logic [1:0]           irqEnable;
    logic                 captureArmed;
    logic                 comparatorPrev;
    sact_pkg::sact_state_t state;
    sact_pkg::sact_state_t next_state;
    logic                 captureEventFlag;
    logic                 counterWrapFlag;

    // Write decode
    wire [9:0] wrIdx     = regWrAddr[11:2];
    wire       wrCntLo   = regWrite & (wrIdx == `SACT_IDX_CNT_LO);
    wire       wrCntHi   = regWrite & (wrIdx == `SACT_IDX_CNT_HI);
    wire       wrCapLo   = regWrite & (wrIdx == `SACT_IDX_CAP_LO);
    wire       wrCapHi   = regWrite & (wrIdx == `SACT_IDX_CAP_HI);
    wire       wrCtrl    = regWrite & (wrIdx == `SACT_IDX_CTRL);
    wire       wrFlags   = regWrite & (wrIdx == `SACT_IDX_FLAGS);
    wire       wrIrqEn   = regWrite & (wrIdx == `SACT_IDX_IRQ_EN);
    wire       cntWrite  = wrCntLo | wrCntHi;
    assign regWrHit = (wrIdx == `SACT_IDX_CNT_LO) | (wrIdx == `SACT_IDX_CNT_HI)
                    | (wrIdx == `SACT_IDX_CAP_LO) | (wrIdx == `SACT_IDX_CAP_HI)
                    | (wrIdx == `SACT_IDX_CTRL)   | (wrIdx == `SACT_IDX_FLAGS)
                    | (wrIdx == `SACT_IDX_IRQ_EN);

    // Read decode
    wire [9:0] rdIdx     = regRdAddr[11:2];
    wire [7:0] flagsView = {6'h00, captureEventFlag, counterWrapFlag};
    assign regRdData = (rdIdx == `SACT_IDX_CNT_LO) ? rampCountTimer[7:0]   :
                       (rdIdx == `SACT_IDX_CNT_HI) ? rampCountTimer[15:8]  :
                       (rdIdx == `SACT_IDX_CAP_LO) ? rampCaptureReg[7:0]   :
                       (rdIdx == `SACT_IDX_CAP_HI) ? rampCaptureReg[15:8]  :
                       (rdIdx == `SACT_IDX_CTRL)   ? (convControlReg & 8'hf7) :
                       (rdIdx == `SACT_IDX_FLAGS)  ? flagsView             :
                       (rdIdx == `SACT_IDX_IRQ_EN) ? {6'h00, irqEnable}    :
                       8'h00;
    assign regRdHit  = (rdIdx == `SACT_IDX_CNT_LO) | (rdIdx == `SACT_IDX_CNT_HI)
                     | (rdIdx == `SACT_IDX_CAP_LO) | (rdIdx == `SACT_IDX_CAP_HI)
                     | (rdIdx == `SACT_IDX_CTRL)   | (rdIdx == `SACT_IDX_FLAGS)
                     | (rdIdx == `SACT_IDX_IRQ_EN);

    // Control register
    wire holdBit     = convControlReg[`SACT_CTRL_HOLD_BIT];
    wire next_hold   = wrCtrl ? regWrData[`SACT_CTRL_HOLD_BIT] : holdBit;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            convControlReg <= `SACT_CTRL_RESET;
            irqEnable      <= 2'h0;
        end else if (ce) begin
            if (wrCtrl) begin
                convControlReg <= regWrData;
            end
            if (wrIrqEn) begin
                irqEnable <= regWrData[1:0];
            end
        end
    end

    // Channel select and analog options straight from the register flops
    assign inputChannelSelect = convControlReg[`SACT_CTRL_CHAN_MSB:`SACT_CTRL_CHAN_LSB];
    assign amuxOutEnable      = convControlReg[`SACT_CTRL_AMUX_BIT];
    assign zeroEnable         = convControlReg[`SACT_CTRL_ZERO_BIT];

    // Conversion state: hold forces idle from any state
    always_comb begin
        next_state = state;
        if (next_hold) begin
            next_state = sact_pkg::SACT_IDLE;
        end else begin
            unique case (state)
                sact_pkg::SACT_IDLE:   next_state = sact_pkg::SACT_RUN;
                sact_pkg::SACT_RUN:    next_state = wrCntHi ? sact_pkg::SACT_PAUSED
                                                            : sact_pkg::SACT_RUN;
                sact_pkg::SACT_PAUSED: next_state = wrCntLo ? sact_pkg::SACT_RUN
                                                            : sact_pkg::SACT_PAUSED;
                default:               next_state = sact_pkg::SACT_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= sact_pkg::SACT_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    wire running = (state == sact_pkg::SACT_RUN);

    // Idle gating saves power between conversions
    assign rampDischarge  = (state == sact_pkg::SACT_IDLE);
    assign rampCurrentOn  = (state != sact_pkg::SACT_IDLE);
    assign analogPowerOn  = (state != sact_pkg::SACT_IDLE);
    assign counterClockOn = running & ce;

    // Counter; a bus write beats the increment and is never cleared by hardware
    wire [15:0] countPlusOne = rampCountTimer + 16'h0001;
    wire        wrapEvent    = ce & running & ~cntWrite
                             & (rampCountTimer == `SACT_CNT_LAST);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            rampCountTimer <= `SACT_CNT_RESET;
        end else if (ce) begin
            if (wrCntLo) begin
                rampCountTimer[7:0] <= regWrData;
            end else if (wrCntHi) begin
                rampCountTimer[15:8] <= regWrData;
            end else if (running) begin
                rampCountTimer <= countPlusOne;
            end
        end
    end

    // Capture on comparator falling edge, once per conversion
    wire captureEvent = ce & running & captureArmed & comparatorPrev & ~comparatorOut;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            comparatorPrev <= 1'b0;
            captureArmed   <= 1'b0;
        end else if (ce) begin
            comparatorPrev <= comparatorOut;
            if (state == sact_pkg::SACT_IDLE) begin
                captureArmed <= 1'b1;
            end else if (captureEvent) begin
                captureArmed <= 1'b0;
            end
        end
    end

    // A capture beats a software write in the same cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rampCaptureReg <= `SACT_CAP_RESET;
        end else if (ce) begin
            if (captureEvent) begin
                rampCaptureReg <= rampCountTimer;
            end else if (wrCapLo) begin
                rampCaptureReg[7:0] <= regWrData;
            end else if (wrCapHi) begin
                rampCaptureReg[15:8] <= regWrData;
            end
        end
    end

    // Sticky flags, write one to clear
    wire clrCap  = wrFlags & regWrData[`SACT_FLAG_CAP_BIT];
    wire clrWrap = wrFlags & regWrData[`SACT_FLAG_WRAP_BIT];

    sact_flag u_cap_flag (
        .clk      (clk),
        .resetn   (resetn),
        .ce       (ce),
        .setEvent (captureEvent),
        .clearReq (clrCap),
        .flag     (captureEventFlag)
    );

    sact_flag u_wrap_flag (
        .clk      (clk),
        .resetn   (resetn),
        .ce       (ce),
        .setEvent (wrapEvent),
        .clearReq (clrWrap),
        .flag     (counterWrapFlag)
    );

    assign captureIrq = captureEventFlag & irqEnable[`SACT_FLAG_CAP_BIT];
    assign wrapIrq    = counterWrapFlag & irqEnable[`SACT_FLAG_WRAP_BIT];

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_hold_freeze;
        (state == sact_pkg::SACT_IDLE) && !cntWrite |=> $stable(rampCountTimer);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze)
        else $error("Counter moved while held");

    property p_hold_discharge;
        next_hold && ce |=> rampDischarge && !rampCurrentOn && !counterClockOn;
    endproperty
    a_hold_discharge: assert property (p_hold_discharge)
        else $error("Ramp not discharged while held");

    property p_release_runs;
        ce && wrCtrl && holdBit && !regWrData[`SACT_CTRL_HOLD_BIT]
            |=> running && rampCurrentOn ##1 (!ce || rampCountTimer != $past(rampCountTimer));
    endproperty
    a_release_runs: assert property (p_release_runs)
        else $error("Release did not start conversion");

    property p_capture_copy;
        captureEvent |=> rampCaptureReg == $past(rampCountTimer) && captureEventFlag;
    endproperty
    a_capture_copy: assert property (p_capture_copy)
        else $error("Capture value or flag wrong");

    property p_capture_irq;
        captureEvent && irqEnable[`SACT_FLAG_CAP_BIT] |=> captureIrq;
    endproperty
    a_capture_irq: assert property (p_capture_irq)
        else $error("Capture interrupt missing");

    property p_keep_counting;
        captureEvent && !cntWrite && !next_hold
            |=> rampCountTimer == $past(rampCountTimer) + 16'h0001;
    endproperty
    a_keep_counting: assert property (p_keep_counting)
        else $error("Counter stopped at capture");

    property p_step_one;
        ce && running && !cntWrite |=> rampCountTimer == $past(rampCountTimer) + 16'h0001;
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("Counter did not step by one");

    property p_wrap;
        ce && running && !cntWrite && rampCountTimer == `SACT_CNT_LAST
            |=> rampCountTimer == 16'h0000 && counterWrapFlag;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Wrap not flagged");

    property p_hi_pause;
        ce && running && wrCntHi && !next_hold |=> state == sact_pkg::SACT_PAUSED ##1
            (!ce || $stable(rampCountTimer) || cntWrite || $past(cntWrite));
    endproperty
    a_hi_pause: assert property (p_hi_pause)
        else $error("High byte write did not stop counting");

    property p_once;
        captureEvent |=> !captureEvent [*2];
    endproperty
    a_once: assert property (p_once)
        else $error("Second capture in one conversion");

    property p_sticky;
        captureEventFlag && !clrCap |=> captureEventFlag;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("Capture flag dropped by itself");

endmodule

// >>> sact_ramp_model.sv
// Purpose: Behavioural ramp and comparator facing the slope capture timer
// Assumes: Ramp passes the input tripAfter cycles after charging starts
// Notes:   Comparator stays low until the next discharge, so one trip per conversion
`timescale 1ns/1ps
module sact_ramp_model (
    // Clock
    input  wire logic        clk,
    // Ramp control
    input  wire logic        rampDischarge,
    input  wire logic        rampCurrentOn,
    input  wire logic [15:0] tripAfter,
    // Comparator
    output logic             comparatorOut
);
    logic [15:0] rampLevel;
    initial begin
        rampLevel = 16'h0000;
        comparatorOut = 1'h1;
    end
    always @(posedge clk) begin
        if (rampDischarge || !rampCurrentOn) begin
            rampLevel <= 16'h0000;
            comparatorOut <= 1'h1;
        end else begin
            rampLevel <= rampLevel + 16'h0001;
            if (rampLevel + 16'h0001 == tripAfter) begin
                comparatorOut <= 1'h0;
            end
        end
    end
endmodule

// >>> sact_top_tb_top.sv
// Purpose: Self-checking bench for the slope capture timer
// Assumes: Byte registers in lane 0; ce held high
// Notes:   Counter read only while stopped, as reads in a run are not latched
`timescale 1ns/1ps
`include "sact_defines.svh"
module sact_top_tb_top;
    logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic        bvalid, arready, rvalid, cmp, dis, cur, cclk, capIrq, wrapIrq, apw, amux, zero;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, keep;
    logic [1:0]  bresp, rresp;
    logic [3:0]  chan;
    int          errCount, checksDone;
    localparam logic [15:0] TRIP = 16'h0064;
    localparam logic [9:0] IDX[4] = '{`SACT_IDX_CAP_LO, `SACT_IDX_CAP_HI,
        `SACT_IDX_CNT_HI, `SACT_IDX_CNT_LO};
    localparam logic [7:0] VAL[4] = '{8'h5a, 8'ha5, 8'h12, 8'h34};

    sact_top u_sact_top (.clk(clk), .ce(1'h1), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comparatorOut(cmp), .rampDischarge(dis),
        .rampCurrentOn(cur), .analogPowerOn(apw), .counterClockOn(cclk),
        .inputChannelSelect(chan), .amuxOutEnable(amux), .zeroEnable(zero),
        .captureIrq(capIrq), .wrapIrq(wrapIrq));
    sact_ramp_model u_sact_ramp_model (.clk(clk), .rampDischarge(dis),
        .rampCurrentOn(cur), .tripAfter(TRIP), .comparatorOut(cmp));

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid && n < 100);
        bready <= 1'h0;
        chk("bresp", {29'h0, bvalid, bresp}, {29'h0, 1'h1, er});
    endtask

    // Reads one byte register into rd and checks the response code
    task rdr(input logic [9:0] idx, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid && n < 100);
        rd = rdata;
        rready <= 1'h0;
        chk("rresp", {29'h0, rvalid, rresp}, {29'h0, 1'h1, er});
    endtask

    task rchk(input string nm, input logic [9:0] idx, input logic [7:0] exp);
        rdr(idx, `SACT_RESP_OKAY);
        chk(nm, rd, {24'h0, exp});
    endtask

    task end_of_test;
        if (errCount == 0 && checksDone > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // A run needs about 20300 cycles; the hold wait dominates
    initial begin
        repeat (50000) @(posedge clk);
        errCount++;
        end_of_test;
    end

    initial begin
        {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0;
        errCount = 0;
        checksDone = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'h1;
        rchk("control", `SACT_IDX_CTRL, `SACT_CTRL_RESET);
        rchk("cntLo", `SACT_IDX_CNT_LO, 8'h00);
        rchk("cntHi", `SACT_IDX_CNT_HI, 8'h00);
        chk("discharge", dis, 1'h1);
        chk("cntClock", cclk, 1'h0);
        for (int i = 0; i < 4; i++) wr(IDX[i], VAL[i], `SACT_RESP_OKAY);
        for (int i = 0; i < 4; i++) rchk("readback", IDX[i], VAL[i]);
        wr(10'h040, 8'h77, `SACT_RESP_SLVERR);
        rdr(10'h040, `SACT_RESP_SLVERR);
        chk("unmapped", rd, 32'h0);
        repeat (20000) @(posedge clk);
        wr(`SACT_IDX_CNT_HI, 8'h00, `SACT_RESP_OKAY);
        wr(`SACT_IDX_CNT_LO, 8'h00, `SACT_RESP_OKAY);
        wr(`SACT_IDX_IRQ_EN, 8'h03, `SACT_RESP_OKAY);
        wr(`SACT_IDX_CTRL, 8'h55, `SACT_RESP_OKAY);
        #1;
        chk("channel", {chan, amux, zero}, 6'h17);
        chk("ramp", {dis, cur, cclk, apw}, 4'h7);
        repeat (150) @(posedge clk);
        #1;
        chk("capIrq", capIrq, 1'h1);
        chk("running", cclk, 1'h1);
        rchk("flags", `SACT_IDX_FLAGS, 8'h02);
        rchk("capLo", `SACT_IDX_CAP_LO, TRIP[7:0]);
        rchk("capHi", `SACT_IDX_CAP_HI, TRIP[15:8]);
        wr(`SACT_IDX_FLAGS, 8'h02, `SACT_RESP_OKAY);
        rchk("flagsClr", `SACT_IDX_FLAGS, 8'h00);
        wr(`SACT_IDX_CNT_HI, 8'hff, `SACT_RESP_OKAY);
        rdr(`SACT_IDX_CNT_LO, `SACT_RESP_OKAY);
        keep = rd;
        rchk("paused", `SACT_IDX_CNT_LO, keep[7:0]);
        wr(`SACT_IDX_CNT_LO, 8'hf0, `SACT_RESP_OKAY);
        repeat (40) @(posedge clk);
        #1;
        chk("wrapIrq", wrapIrq, 1'h1);
        rchk("wrapFlag", `SACT_IDX_FLAGS, 8'h01);
        wr(`SACT_IDX_CTRL, 8'h52, `SACT_RESP_OKAY);
        #1;
        chk("held", {dis, cur, cclk, apw, amux, zero}, 6'h20);
        rdr(`SACT_IDX_CNT_LO, `SACT_RESP_OKAY);
        keep = rd;
        repeat (10) @(posedge clk);
        rchk("stopped", `SACT_IDX_CNT_LO, keep[7:0]);
        end_of_test;
    end
endmodule
